// ### verilog/io_adapter_host_side.v
// Host-bus slave decode, request queue and master arbitration of the I/O adapter
`timescale 1ns/1ps
`include "io_adapter_map.vh"
module io_adapter_host_side #(
  parameter QDEPTH = 4
) (
  input  wire        sys_clk,
  input  wire        rstn,
  // Host bus snoop
  input  wire        hb_valid,
  input  wire [63:0] hb_data,
  input  wire [3:0]  hb_cmd,
  input  wire [2:0]  hb_id,
  input  wire        hb_parity,
  input  wire        hb_is_quad,
  input  wire        hb_write,
  input  wire [63:0] hb_wdata,
  output reg         hb_ack_n,
  output wire        queue_full_suppress_n,
  // Port controllers
  output wire        p1_req_valid,
  output wire [31:0] p1_req_addr,
  output wire [63:0] p1_req_wdata,
  output wire        p1_req_write,
  input  wire        p1_done,
  output wire        p2_req_valid,
  output wire [31:0] p2_req_addr,
  output wire [63:0] p2_req_wdata,
  output wire        p2_req_write,
  input  wire        p2_done,
  output wire        vector_read,
  output wire [1:0]  vector_index,
  // Master sources
  input  wire        p1_rd_valid,
  input  wire        p1_wr_valid,
  input  wire        p1_ior_valid,
  input  wire        p2_rd_valid,
  input  wire        p2_wr_valid,
  input  wire        p2_ior_valid,
  output reg  [6:0]  src_taken,
  output wire        io1_request,
  output wire        io2_request,
  input  wire        io1_grant,
  input  wire        io2_grant,
  output reg         mst_drive,
  output reg  [63:0] mst_data,
  output reg  [3:0]  mst_cmd,
  output reg  [2:0]  mst_id,
  output reg  [2:0]  mst_src,
  input  wire        hold_enable,
  output wire [31:0] interval_clock_control_status_out,
  output wire [31:0] next_count_out
);

  // ---------------------------------------------------------------------------
  // Decode
  // ---------------------------------------------------------------------------
  function in_rng;
    input [31:0] a;
    input [31:0] lo;
    input [31:0] hi;
    begin
      in_rng = (a >= lo) && (a <= hi);
    end
  endfunction

  reg  [31:0] csr_ff;
  wire        ext_en = csr_ff[`CSR_EXT_EN_BIT];
  wire [31:0] a      = hb_data[31:0];
  wire        hit_p1 = in_rng(a, `P1_LOW_BASE, `P1_LOW_LAST)
                     | in_rng(a, `P1_HIGH_BASE, `P1_HIGH_LAST);
  wire        hit_p2 = in_rng(a, `P2_LOW_BASE, `P2_LOW_LAST)
                     | in_rng(a, `P2_MID_BASE, `P2_MID_LAST)
                     | in_rng(a, `P2_HIGH_BASE, `P2_HIGH_LAST)
                     | (ext_en & (in_rng(a, `P2_EXT_A_BASE, `P2_EXT_A_LAST)
                     | in_rng(a, `P2_EXT_B_BASE, `P2_EXT_B_LAST)));
  wire        hit_ic   = (a[31:2] == `INTERVAL_CLOCK_CONTROL_STATUS_ADDR >> 2);
  wire        hit_nc   = (a[31:2] == `NEXT_COUNT_ADDR >> 2);
  wire        hit_cnt  = (a[31:2] == `COUNT_ADDR >> 2);
  wire        hit_vec  = in_rng(a, `VECTOR_BASE, `VECTOR_LAST) & ~hb_write;
  wire        hit_csr  = in_rng(a, `CSR_BASE, `CSR_LAST);
  wire        hit_reg  = hit_ic | hit_nc | hit_cnt | hit_csr;
  wire        addr_cyc = hb_valid & ((hb_cmd == `CMD_READ) | (hb_cmd == `CMD_WRITE));
  wire        par_ok   = ~(^{hb_data, hb_cmd, hb_id, hb_parity});

  // ---------------------------------------------------------------------------
  // Request queue
  // ---------------------------------------------------------------------------
  reg         q_valid_ff [0:QDEPTH-1];
  reg         q_port_ff  [0:QDEPTH-1];
  reg         q_wr_ff    [0:QDEPTH-1];
  reg  [1:0]  q_tok_ff   [0:QDEPTH-1];
  reg  [31:0] q_addr_ff  [0:QDEPTH-1];
  reg  [63:0] q_data_ff  [0:QDEPTH-1];
  reg  [1:0]  tok_in_ff  [0:1];
  reg  [1:0]  tok_exp_ff [0:1];
  reg  [2:0]  free_idx;
  reg  [2:0]  p1_idx;
  reg  [2:0]  p2_idx;
  reg         q_full;
  integer     i, j;

  always @* begin
    free_idx = 3'h4;
    p1_idx   = 3'h4;
    p2_idx   = 3'h4;
    q_full   = 1'b1;
    for (i = QDEPTH - 1; i >= 0; i = i - 1) begin
      if (!q_valid_ff[i]) begin
        free_idx = i[2:0];
        q_full   = 1'b0;
      end
      if (q_valid_ff[i] && !q_port_ff[i] && q_tok_ff[i] == tok_exp_ff[0]) begin
        p1_idx = i[2:0];
      end
      if (q_valid_ff[i] && q_port_ff[i] && q_tok_ff[i] == tok_exp_ff[1]) begin
        p2_idx = i[2:0];
      end
    end
  end

  wire io_hit  = hit_p1 | hit_p2;
  wire own     = addr_cyc & par_ok & (io_hit | hit_reg | hit_vec);
  wire io_acc  = addr_cyc & par_ok & io_hit & ~q_full;
  wire reg_acc = addr_cyc & par_ok & hit_reg;

  assign queue_full_suppress_n = ~q_full;
  assign p1_req_valid = ~p1_idx[2];
  assign p2_req_valid = ~p2_idx[2];
  assign p1_req_addr  = q_addr_ff[p1_idx[1:0]];
  assign p1_req_wdata = q_data_ff[p1_idx[1:0]];
  assign p1_req_write = q_wr_ff[p1_idx[1:0]];
  assign p2_req_addr  = q_addr_ff[p2_idx[1:0]];
  assign p2_req_wdata = q_data_ff[p2_idx[1:0]];
  assign p2_req_write = q_wr_ff[p2_idx[1:0]];
  assign vector_read  = addr_cyc & par_ok & hit_vec;
  assign vector_index = a[3:2];

  always @(posedge sys_clk) begin
    if (!rstn) begin
      hb_ack_n <= 1'b1;
      for (j = 0; j < QDEPTH; j = j + 1) begin
        q_valid_ff[j] <= 1'b0;
        q_port_ff[j]  <= 1'b0;
        q_wr_ff[j]    <= 1'b0;
        q_tok_ff[j]   <= 2'h0;
        q_addr_ff[j]  <= 32'h00000000;
        q_data_ff[j]  <= 64'h0000000000000000;
      end
      for (j = 0; j < 2; j = j + 1) begin
        tok_in_ff[j]  <= 2'h0;
        tok_exp_ff[j] <= 2'h0;
      end
    end else begin
      hb_ack_n <= ~((io_acc | reg_acc | vector_read) & own);
      if (p1_done && p1_req_valid) begin
        q_valid_ff[p1_idx[1:0]] <= 1'b0;
        tok_exp_ff[0] <= tok_exp_ff[0] + 2'h1;
      end
      if (p2_done && p2_req_valid) begin
        q_valid_ff[p2_idx[1:0]] <= 1'b0;
        tok_exp_ff[1] <= tok_exp_ff[1] + 2'h1;
      end
      if (io_acc) begin
        q_valid_ff[free_idx[1:0]] <= 1'b1;
        q_port_ff[free_idx[1:0]]  <= hit_p2;
        q_wr_ff[free_idx[1:0]]    <= hb_write;
        q_tok_ff[free_idx[1:0]]   <= tok_in_ff[hit_p2];
        q_addr_ff[free_idx[1:0]]  <= {a[31:3], 3'h0};
        q_data_ff[free_idx[1:0]]  <= hb_is_quad ? hb_wdata : {32'h00000000, hb_wdata[31:0]};
        tok_in_ff[hit_p2]         <= tok_in_ff[hit_p2] + 2'h1;
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Registers and read-return buffer
  // ---------------------------------------------------------------------------
  reg  [31:0] interval_clock_control_status_ff;
  reg  [31:0] next_cnt_ff;
  reg  [31:0] count_ff;
  reg  [31:0] rd_val;
  wire        tx_in_ready;
  wire        tx_valid;
  wire [66:0] tx_data;
  wire        tx_pop;

  always @* begin
    rd_val = 32'h00000000;
    if (hit_ic) begin
      rd_val = interval_clock_control_status_ff;
    end else if (hit_cnt) begin
      rd_val = count_ff;
    end else if (hit_csr && a[4:2] == 3'h0) begin
      rd_val = csr_ff;
    end
  end

  always @(posedge sys_clk) begin
    if (!rstn) begin
      interval_clock_control_status_ff     <= `INTERVAL_CLOCK_CONTROL_STATUS_RESET;
      next_cnt_ff <= `NEXT_COUNT_RESET;
      count_ff    <= `COUNT_RESET;
      csr_ff      <= `CSR_RESET;
    end else begin
      count_ff <= count_ff + 32'h00000001;
      if (reg_acc && hb_write) begin
        if (hit_ic) begin
          interval_clock_control_status_ff <= hb_wdata[31:0];
        end
        if (hit_nc) begin
          next_cnt_ff <= hb_wdata[31:0];
          count_ff    <= hb_wdata[31:0];
        end
        if (hit_csr && a[4:2] == 3'h0) begin
          csr_ff <= hb_wdata[31:0];
        end
      end
    end
  end

  assign interval_clock_control_status_out       = interval_clock_control_status_ff;
  assign next_count_out = next_cnt_ff;

  req_fifo #(
    .WIDTH (67),
    .DEPTH (4),
    .AW    (2)
  ) u_tx_buf (
    .sys_clk   (sys_clk),
    .rstn      (rstn),
    .in_valid  (reg_acc & ~hb_write),
    .in_ready  (tx_in_ready),
    .in_data   ({hb_id, 32'h00000000, rd_val}),
    .out_valid (tx_valid),
    .out_ready (tx_pop),
    .out_data  (tx_data)
  );

  // ---------------------------------------------------------------------------
  // Master arbitration
  // ---------------------------------------------------------------------------
  reg  [2:0]  sel1;
  reg  [2:0]  sel2;
  reg         own_ff;
  reg         held_ff;
  reg         grp_ff;

  always @* begin
    sel1 = 3'h7;
    if (p1_rd_valid) begin
      sel1 = `SRC_P1_RD;
    end else if (p1_wr_valid) begin
      sel1 = `SRC_P1_WR;
    end else if (p1_ior_valid) begin
      sel1 = `SRC_P1_IOR;
    end else if (tx_valid) begin
      sel1 = `SRC_REG;
    end
    sel2 = 3'h7;
    if (p2_rd_valid) begin
      sel2 = `SRC_P2_RD;
    end else if (p2_wr_valid) begin
      sel2 = `SRC_P2_WR;
    end else if (p2_ior_valid) begin
      sel2 = `SRC_P2_IOR;
    end
  end

  wire ret1 = (p1_ior_valid & ~src_taken[2]) | tx_valid;
  wire ret2 = p2_ior_valid & ~src_taken[6];
  assign io1_request = (sel1 != 3'h7) & ~own_ff;
  assign io2_request = (sel2 != 3'h7) & ~own_ff;
  wire start1 = io1_grant & (sel1 != 3'h7) & ~own_ff;
  wire start2 = io2_grant & (sel2 != 3'h7) & ~own_ff & ~start1;
  wire extra  = own_ff & hold_enable & ~held_ff & (grp_ff ? ret2 : ret1);
  wire [2:0] extra_src = grp_ff ? `SRC_P2_IOR : ((p1_ior_valid & ~src_taken[2]) ? `SRC_P1_IOR : `SRC_REG);
  wire [2:0] go_src = start1 ? sel1 : (start2 ? sel2 : extra_src);
  wire go = start1 | start2 | extra;
  assign tx_pop = go & (go_src == `SRC_REG);

  always @(posedge sys_clk) begin
    if (!rstn) begin
      own_ff    <= 1'b0;
      held_ff   <= 1'b0;
      grp_ff    <= 1'b0;
      mst_drive <= 1'b0;
      mst_data  <= 64'h0000000000000000;
      mst_cmd   <= 4'h0;
      mst_id    <= 3'h0;
      mst_src   <= 3'h0;
      src_taken <= 7'h00;
    end else begin
      mst_drive <= go;
      src_taken <= go ? (7'h01 << go_src) : 7'h00;
      own_ff    <= start1 | start2 | extra;
      held_ff   <= extra;
      if (start1 | start2) begin
        grp_ff <= start2;
      end
      if (go) begin
        mst_src  <= go_src;
        mst_data <= (go_src == `SRC_REG) ? tx_data[63:0] : 64'h0000000000000000;
        mst_id   <= (go_src == `SRC_REG) ? tx_data[66:64] : 3'h0;
        case (go_src)
          `SRC_P1_RD, `SRC_P2_RD: begin
            mst_cmd <= `CMD_DMA_READ;
          end
          `SRC_P1_WR, `SRC_P2_WR: begin
            mst_cmd <= `CMD_DMA_WRITE;
          end
          default: begin
            mst_cmd <= `CMD_RDATA;
          end
        endcase
      end
    end
  end

endmodule // io_adapter_host_side

// ### verilog/io_adapter_map.vh
// Address map, field layout and reset values of the host-bus side of the I/O adapter
`ifndef IO_ADAPTER_MAP_VH
`define IO_ADAPTER_MAP_VH

// -----------------------------------------------------------------------------
// Peripheral port windows
// -----------------------------------------------------------------------------
`define P2_LOW_BASE      32'h20000000
`define P2_LOW_LAST      32'h20003FFF
`define P1_LOW_BASE      32'h20004000
`define P1_LOW_LAST      32'h2000FFFF
`define P2_MID_BASE      32'h20010000
`define P2_MID_LAST      32'h20FFFFFF
`define P2_EXT_A_BASE    32'h21030000
`define P2_EXT_A_LAST    32'h2103FFFF
`define P1_HIGH_BASE     32'h21040000
`define P1_HIGH_LAST     32'h27FFFFFF
`define P2_HIGH_BASE     32'h28000000
`define P2_HIGH_LAST     32'h2FFFFFFF
`define P2_EXT_B_BASE    32'h30000000
`define P2_EXT_B_LAST    32'h3FFFFFFF

// -----------------------------------------------------------------------------
// Adapter registers
// -----------------------------------------------------------------------------
`define INTERVAL_CLOCK_CONTROL_STATUS_ADDR        32'h21000060
`define NEXT_COUNT_ADDR  32'h21000064
`define COUNT_ADDR       32'h21000068
`define VECTOR_BASE      32'h21000100
`define VECTOR_LAST      32'h2100010F
`define CSR_BASE         32'h21020000
`define CSR_LAST         32'h2102001F
`define CSR_EXT_EN_BIT   0
`define INTERVAL_CLOCK_CONTROL_STATUS_RESET       32'h00000000
`define NEXT_COUNT_RESET 32'h00000000
`define COUNT_RESET      32'h00000000
`define CSR_RESET        32'h00000000

// -----------------------------------------------------------------------------
// Host-bus command codes
// -----------------------------------------------------------------------------
`define CMD_READ         4'h1
`define CMD_WRITE        4'h2
`define CMD_RDATA        4'h3
`define CMD_DMA_READ     4'h4
`define CMD_DMA_WRITE    4'h5

// -----------------------------------------------------------------------------
// Master sources
// -----------------------------------------------------------------------------
`define SRC_P1_RD        3'h0
`define SRC_P1_WR        3'h1
`define SRC_P1_IOR       3'h2
`define SRC_REG          3'h3
`define SRC_P2_RD        3'h4
`define SRC_P2_WR        3'h5
`define SRC_P2_IOR       3'h6

`endif

// ### verilog/req_fifo.v
// Small valid/ready FIFO used for the register read-return path
`timescale 1ns/1ps
module req_fifo #(
  parameter WIDTH = 72,
  parameter DEPTH = 4,
  parameter AW    = 2
) (
  input  wire             sys_clk,
  input  wire             rstn,
  input  wire             in_valid,
  output wire             in_ready,
  input  wire [WIDTH-1:0] in_data,
  output wire             out_valid,
  input  wire             out_ready,
  output wire [WIDTH-1:0] out_data
);

  reg [WIDTH-1:0] mem_ff [0:DEPTH-1];
  reg [AW-1:0]    wptr_ff;
  reg [AW-1:0]    rptr_ff;
  reg [AW:0]      cnt_ff;
  wire            push;
  wire            pop;

  assign in_ready  = (cnt_ff != DEPTH[AW:0]);
  assign out_valid = (cnt_ff != {(AW+1){1'b0}});
  assign out_data  = mem_ff[rptr_ff];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  always @(posedge sys_clk) begin
    if (push) begin
      mem_ff[wptr_ff] <= in_data;
    end
  end

  always @(posedge sys_clk) begin
    if (!rstn) begin
      wptr_ff <= {AW{1'b0}};
      rptr_ff <= {AW{1'b0}};
      cnt_ff  <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wptr_ff <= (wptr_ff == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wptr_ff + 1'b1;
      end
      if (pop) begin
        rptr_ff <= (rptr_ff == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rptr_ff + 1'b1;
      end
      cnt_ff <= cnt_ff + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    end
  end

endmodule // req_fifo

// ### sim/io_adapter_monitor.sv
// Checker of host-bus acknowledge and master arbitration
`timescale 1ns/1ps
`include "io_adapter_map.vh"
module io_adapter_monitor (
  input wire        sys_clk,
  input wire        rstn,
  input wire        hb_valid,
  input wire [63:0] hb_data,
  input wire [3:0]  hb_cmd,
  input wire [2:0]  hb_id,
  input wire        hb_parity,
  input wire        hb_ack_n,
  input wire        queue_full_suppress_n,
  input wire        p1_done,
  input wire        p2_done,
  input wire        p1_rd_valid,
  input wire        p1_wr_valid,
  input wire        p1_ior_valid,
  input wire        p2_rd_valid,
  input wire        p2_wr_valid,
  input wire        p2_ior_valid,
  input wire [6:0]  src_taken,
  input wire        io1_request,
  input wire        io2_request,
  input wire        io1_grant,
  input wire        io2_grant,
  input wire        mst_drive,
  input wire [2:0]  mst_src,
  input wire        hold_enable
);
  wire [31:0] a       = hb_data[31:0];
  wire        bad_par = ^{hb_data, hb_cmd, hb_id, hb_parity};
  wire        gap     = (a >= 32'h21000000 && a <= 32'h2100005F) || (a >= 32'h2100006C && a <= 32'h210000FF) ||
                        (a >= 32'h21000110 && a <= 32'h2101FFFF) || (a >= 32'h21020020 && a <= 32'h2102FFFF);
  wire        p1_win  = (a >= `P1_LOW_BASE && a <= `P1_LOW_LAST) || (a >= `P1_HIGH_BASE && a <= `P1_HIGH_LAST);
  wire        any1    = p1_rd_valid || p1_wr_valid || p1_ior_valid;
  wire        any2    = p2_rd_valid || p2_wr_valid || p2_ior_valid;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  // ----
  // Properties
  // ----
  property p_ack_cause;
    !hb_ack_n |-> $past(hb_valid && !bad_par && (hb_cmd == `CMD_READ || hb_cmd == `CMD_WRITE));
  endproperty
  a_ack_cause: assert property (p_ack_cause)
    else $error("ack without good address cycle");
  property p_bad_par; $past(hb_valid && bad_par) |-> hb_ack_n; endproperty
  a_bad_par: assert property (p_bad_par)
    else $error("ack after parity error");
  property p_gap; $past(hb_valid && gap) |-> hb_ack_n; endproperty
  a_gap: assert property (p_gap)
    else $error("ack in unmapped range");
  property p_full; $past(hb_valid && p1_win && !queue_full_suppress_n && !p1_done && !p2_done) |-> hb_ack_n; endproperty
  a_full: assert property (p_full)
    else $error("io ack while queue full");
  property p_taken; mst_drive |-> src_taken == (7'h01 << mst_src); endproperty
  a_taken: assert property (p_taken)
    else $error("taken flag differs from driven source");
  property p_p1_order; io1_grant && io1_request && p1_rd_valid |=> mst_drive && mst_src == `SRC_P1_RD; endproperty
  a_p1_order: assert property (p_p1_order)
    else $error("port one read not first");
  property p_p2_order; io2_grant && io2_request && p2_rd_valid |=> mst_drive && mst_src == `SRC_P2_RD; endproperty
  a_p2_order: assert property (p_p2_order)
    else $error("port two read not first");
  property p_one; mst_drive && !hold_enable |=> !mst_drive; endproperty
  a_one: assert property (p_one)
    else $error("second drive without hold");
  property p_req; !mst_drive && (any1 || any2) |-> (!any1 || io1_request) && (!any2 || io2_request); endproperty
  a_req: assert property (p_req)
    else $error("pending source without request");
  c_ack: cover property (!hb_ack_n);
  c_full: cover property (!queue_full_suppress_n);
  c_hold: cover property (mst_drive ##1 mst_drive);
endmodule // io_adapter_monitor

bind io_adapter_host_side io_adapter_monitor i_mon (.sys_clk, .rstn, .hb_valid, .hb_data, .hb_cmd, .hb_id,
  .hb_parity, .hb_ack_n, .queue_full_suppress_n, .p1_done, .p2_done, .p1_rd_valid, .p1_wr_valid, .p1_ior_valid,
  .p2_rd_valid, .p2_wr_valid, .p2_ior_valid, .src_taken, .io1_request, .io2_request, .io1_grant, .io2_grant,
  .mst_drive, .mst_src, .hold_enable);

// ### sim/host_arbiter_model.sv
// Host-bus arbiter model granting the two adapter ports
`timescale 1ns/1ps
module host_arbiter_model (
  input  wire       sys_clk,
  input  wire       rstn,
  input  wire [3:0] grant_delay,
  input  wire       io1_request,
  input  wire       io2_request,
  output reg        io1_grant,
  output reg        io2_grant
);
  reg [3:0] wait_ff;
  reg       last_two_ff;
  // ----
  // One-cycle grants after a delay
  // ----
  always @(posedge sys_clk) begin
    if (!rstn) begin
      wait_ff     <= 4'h0;
      last_two_ff <= 1'h0;
      io1_grant   <= 1'h0;
      io2_grant   <= 1'h0;
    end else if (io1_grant || io2_grant || !(io1_request || io2_request)) begin
      wait_ff   <= 4'h0;
      io1_grant <= 1'h0;
      io2_grant <= 1'h0;
    end else if (wait_ff < grant_delay) begin
      wait_ff   <= wait_ff + 4'h1;
      io1_grant <= 1'h0;
      io2_grant <= 1'h0;
    end else if (io2_request && (!io1_request || !last_two_ff)) begin
      io1_grant   <= 1'h0;
      io2_grant   <= 1'h1;
      last_two_ff <= 1'h1;
    end else begin
      io1_grant   <= 1'h1;
      io2_grant   <= 1'h0;
      last_two_ff <= 1'h0;
    end
  end
endmodule // host_arbiter_model

// ### sim/test_io_adapter_host_side.sv
// Testbench of the host-bus side of the I/O adapter
`timescale 1ns/1ps
`include "io_adapter_map.vh"
module test_io_adapter_host_side;
  reg         sys_clk = 1'h0, rstn = 1'h0, hb_valid = 1'h0, hb_parity = 1'h0, hb_write = 1'h0;
  reg         p1_done = 1'h0, p2_done = 1'h0, hold_enable = 1'h0, an, vec, hb_is_quad = 1'h1;
  reg  [63:0] hb_data = 64'h0, hb_wdata = 64'h0;
  reg  [3:0]  hb_cmd = 4'h0, grant_delay = 4'h0;
  reg  [2:0]  hb_id = 3'h5;
  reg  [5:0]  src_v = 6'h00;
  reg  [1:0]  vidx;
  wire        hb_ack_n, queue_full_suppress_n, vector_read, io1_request, io2_request, io1_grant, io2_grant;
  wire        mst_drive, p1_req_valid, p1_req_write, p2_req_valid, p2_req_write;
  wire [31:0] p1_req_addr, p2_req_addr, interval_clock_control_status_out, next_count_out;
  wire [63:0] p1_req_wdata, p2_req_wdata, mst_data;
  wire [3:0]  mst_cmd;
  wire [1:0]  vector_index;
  wire [6:0]  src_taken;
  wire [2:0]  mst_src, mst_id;
  integer     err_count = 0, num_checks = 0, i, k;
  reg  [2:0]  mlog [$];
  reg  [3:0]  clog [$];
  reg  [63:0] ret_data = 64'h0;
  reg  [2:0]  ret_id = 3'h0;
  reg  [31:0] fa [0:3] = '{32'h20004008, 32'h20000010, 32'h21040018, 32'h28000020};
  reg  [33:0] tbl [0:25] = '{34'h2_20000000, 34'h2_20003FFF, 34'h1_20004000, 34'h1_2000FFFF, 34'h2_20010000,
    34'h2_20FFFFFF, 34'h0_2100005F, 34'h3_21000060, 34'h3_21000064, 34'h3_21000068, 34'h0_2100006C,
    34'h0_210000FF, 34'h3_21000100, 34'h3_2100010F, 34'h0_21000110, 34'h0_2101FFFF, 34'h3_21020000,
    34'h3_2102001F, 34'h0_21020020, 34'h0_21030000, 34'h1_21040000, 34'h1_27FFFFFF, 34'h2_28000000,
    34'h2_2FFFFFFF, 34'h0_30000000, 34'h0_3FFFFFFF};

  io_adapter_host_side #(.QDEPTH(4)) i_dut (.sys_clk, .rstn, .hb_valid, .hb_data, .hb_cmd, .hb_id, .hb_parity,
    .hb_is_quad, .hb_write, .hb_wdata, .hb_ack_n, .queue_full_suppress_n, .p1_req_valid, .p1_req_addr,
    .p1_req_wdata, .p1_req_write, .p1_done, .p2_req_valid, .p2_req_addr, .p2_req_wdata, .p2_req_write, .p2_done,
    .vector_read, .vector_index, .p1_rd_valid(src_v[0]), .p1_wr_valid(src_v[1]), .p1_ior_valid(src_v[2]),
    .p2_rd_valid(src_v[3]), .p2_wr_valid(src_v[4]), .p2_ior_valid(src_v[5]), .src_taken, .io1_request,
    .io2_request, .io1_grant, .io2_grant, .mst_drive, .mst_data, .mst_cmd, .mst_id, .mst_src,
    .hold_enable, .interval_clock_control_status_out, .next_count_out);
  host_arbiter_model i_arb (.sys_clk, .rstn, .grant_delay, .io1_request, .io2_request, .io1_grant, .io2_grant);

  always #2.5 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    if (mst_drive) begin
      mlog.push_back(mst_src);
      clog.push_back(mst_cmd);
    end
    if (mst_drive && mst_src == `SRC_REG) begin
      ret_data <= mst_data;
      ret_id   <= mst_id;
    end
    src_v <= src_v & ~{src_taken[6:4], src_taken[2:0]};
  end
  // ----
  // Tasks
  // ----
  task check(input [63:0] seen, input [63:0] exp, input [8*8:1] what);
    begin
      num_checks = num_checks + 1;
      if (seen !== exp) begin
        err_count = err_count + 1;
        $display("[ERR] %0s expected %0h seen %0h", what, exp, seen);
      end
    end
  endtask
  task hb_cycle(input [31:0] a, input wr, input [63:0] wd, input bad);
    begin
      @(posedge sys_clk);
      #1 hb_valid = 1'h1;
      hb_data = {32'h0, a};
      hb_cmd = wr ? `CMD_WRITE : `CMD_READ;
      hb_write = wr;
      hb_wdata = wd;
      hb_parity = ^{hb_data, hb_cmd, hb_id} ^ bad;
      #2 vec = vector_read;
      vidx = vector_index;
      @(posedge sys_clk);
      #1 hb_valid = 1'h0;
      an = hb_ack_n;
    end
  endtask
  task serve(input p, input [31:0] a, input wr, input [63:0] wd);
    begin
      check(p ? p2_req_valid : p1_req_valid, 1, "req_vld");
      check(p ? p2_req_addr : p1_req_addr, {a[31:3], 3'h0}, "req_addr");
      check(p ? p2_req_write : p1_req_write, wr, "req_wr");
      if (wr)
        check(p ? p2_req_wdata : p1_req_wdata, wd, "req_data");
      @(posedge sys_clk);
      #1 p1_done = !p;
      p2_done = p;
      @(posedge sys_clk);
      #1 p1_done = 1'h0;
      p2_done = 1'h0;
    end
  endtask
  task access(input [31:0] a, input [1:0] kind, input wr, input [63:0] wd);
    begin
      hb_cycle(a, wr, wd, 1'h0);
      check(an, kind == 2'h0, "ack_n");
      if (kind == 2'h1 || kind == 2'h2)
        serve(kind == 2'h2, a, wr, wd);
    end
  endtask
  task run_src(input [5:0] v, input [17:0] exp, input integer n);
    begin
      mlog.delete();
      clog.delete();
      @(posedge sys_clk);
      #1 src_v = v;
      for (k = 0; k < 100 && src_v != 6'h00; k = k + 1)
        @(posedge sys_clk);
      repeat (4) @(posedge sys_clk);
      check(mlog.size(), n, "log_len");
      for (k = 0; k < n; k = k + 1) begin
        check(mlog[k], exp[3*k +: 3], "src");
        check(clog[k], (exp[3*k +: 2] == 2'h0) ? `CMD_DMA_READ
                       : ((exp[3*k +: 2] == 2'h1) ? `CMD_DMA_WRITE : `CMD_RDATA), "cmd");
      end
    end
  endtask
  task close_out;
    begin
      $display("checks %0d errors %0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0)
        $display("All tests passed");
      else
        $display("Some tests failed");
      $finish;
    end
  endtask
  // ----
  // Sequence
  // ----
  initial begin
    repeat (2) @(posedge sys_clk);
    #1 rstn = 1'h1;
    check(queue_full_suppress_n, 1, "suppr_n");
    check(interval_clock_control_status_out, `INTERVAL_CLOCK_CONTROL_STATUS_RESET, "interval_clock_control_status");
    check(next_count_out, `NEXT_COUNT_RESET, "next_cnt");
    for (i = 0; i < 26; i = i + 1)
      access(tbl[i][31:0], tbl[i][33:32], 1'h0, 64'h0);
    hb_cycle(32'h2100010C, 1'h0, 64'h0, 1'h0);
    check(vec, 1, "vec_rd");
    check(vidx, 2'h3, "vec_idx");
    access(`INTERVAL_CLOCK_CONTROL_STATUS_ADDR, 2'h3, 1'h1, {2{32'h00000041}});
    check(interval_clock_control_status_out, 32'h00000041, "interval_clock_control_status");
    access(`INTERVAL_CLOCK_CONTROL_STATUS_ADDR, 2'h3, 1'h0, 64'h0);
    repeat (8) @(posedge sys_clk);
    check(ret_data, 64'h0000000000000041, "ret_data");
    check(ret_id, 3'h5, "ret_id");
    access(`NEXT_COUNT_ADDR, 2'h3, 1'h1, {2{32'h00001234}});
    check(next_count_out, 32'h00001234, "next_cnt");
    access(`CSR_BASE, 2'h3, 1'h1, {2{32'h00000001}});
    access(32'h2103FFF8, 2'h2, 1'h0, 64'h0);
    access(32'h3FFFFFF0, 2'h2, 1'h0, 64'h0);
    hb_cycle(32'h20004000, 1'h1, 64'hA5, 1'h1);
    check(an, 1, "ack_n");
    check(p1_req_valid, 0, "req_vld");
    for (i = 0; i < 4; i = i + 1) begin
      hb_cycle(fa[i], 1'h1, {fa[i], fa[i]}, 1'h0);
      check(an, 0, "ack_n");
    end
    check(queue_full_suppress_n, 0, "suppr_n");
    hb_cycle(32'h20004000, 1'h0, 64'h0, 1'h0);
    check(an, 1, "ack_n");
    serve(1'h1, fa[1], 1'h1, {fa[1], fa[1]});
    check(queue_full_suppress_n, 1, "suppr_n");
    hb_is_quad = 1'h0;
    hb_cycle(32'h2FFFFFF8, 1'h1, 64'h000000AA00000055, 1'h0);
    hb_is_quad = 1'h1;
    check(an, 0, "ack_n");
    serve(1'h1, fa[3], 1'h1, {fa[3], fa[3]});
    serve(1'h1, 32'h2FFFFFF8, 1'h1, 64'h55);
    serve(1'h0, fa[0], 1'h1, {fa[0], fa[0]});
    serve(1'h0, fa[2], 1'h1, {fa[2], fa[2]});
    check(p1_req_valid | p2_req_valid, 0, "req_vld");
    repeat (20) @(posedge sys_clk);
    run_src(6'h07, {9'h0, 3'h2, 3'h1, 3'h0}, 3);
    #1 grant_delay = 4'h3;
    run_src(6'h38, {9'h0, 3'h6, 3'h5, 3'h4}, 3);
    #1 hold_enable = 1'h1;
    run_src(6'h06, {12'h0, 3'h2, 3'h1}, 2);
    #1 hold_enable = 1'h0;
    grant_delay = 4'h1;
    run_src(6'h09, {12'h0, 3'h0, 3'h4}, 2);
    close_out;
  end
  initial begin
    #100000 err_count = err_count + 1;
    close_out;
  end
endmodule // test_io_adapter_host_side
